// ==== protection_cfg_pkg.sv ====
// Package with command codes, field layouts, defaults and timing counts for the config bank.
package protection_cfg_pkg;
	localparam int CLK_HZ = 25_000_000;
	localparam int CYC_PER_US = CLK_HZ / 1_000_000;
	localparam int UV_DLY0_US = 10;
	localparam int UV_DLY1_US = 20;
	localparam int UV_DLY2_US = 40;
	localparam int UV_DLY3_US = 120;
	localparam logic [11:0] UV_DLY0_CYC = 12'(UV_DLY0_US * CYC_PER_US);
	localparam logic [11:0] UV_DLY1_CYC = 12'(UV_DLY1_US * CYC_PER_US);
	localparam logic [11:0] UV_DLY2_CYC = 12'(UV_DLY2_US * CYC_PER_US);
	localparam logic [11:0] UV_DLY3_CYC = 12'(UV_DLY3_US * CYC_PER_US);
	localparam int STRAP_SETTLE = 3;

	localparam logic [7:0] CMD_BANK_SELECT = 8'hDE;
	localparam logic [7:0] CMD_PROT_DISABLE = 8'hDF;
	localparam logic [7:0] CMD_UV_CFG = 8'hE1;
	localparam logic [7:0] CMD_PS_TUNE = 8'hE2;
	localparam logic [7:0] CMD_MOD_TUNE = 8'hE3;
	localparam logic [7:0] CMD_TRIMS = 8'hE4;

	localparam int W_BANK = 3;
	localparam int W_PROT = 9;
	localparam int W_UV = 7;
	localparam int W_PS = 12;
	localparam int W_MOD = 14;
	localparam int W_TRIM = 10;
	localparam int W_ROW = W_PROT + W_UV + W_PS + W_MOD + W_TRIM;
	localparam int ROW_PROT = 0;
	localparam int ROW_UV = ROW_PROT + W_PROT;
	localparam int ROW_PS = ROW_UV + W_UV;
	localparam int ROW_MOD = ROW_PS + W_PS;
	localparam int ROW_TRIM = ROW_MOD + W_MOD;
	localparam int NUM_BANKS = 8;

	localparam logic [7:0] WP_LEVEL_CFG = 8'h10;
	localparam logic [7:0] WP_LEVEL_TRIM = 8'h20;

	localparam logic [W_PROT-1:0] DEF_PROT = 9'h000;
	localparam logic [W_UV-1:0] DEF_UV = 7'h00;
	localparam logic [W_PS-1:0] DEF_PS = 12'h000;
	localparam logic [W_MOD-1:0] DEF_MOD = 14'h0000;
	localparam logic [W_TRIM-1:0] DEF_TRIM = 10'h000;

	localparam int UV_LEVEL_LSB = 0;
	localparam int UV_DELAY_LSB = 4;
	localparam int UV_ACTION_BIT = 6;
	localparam int PS_CLAMP_LSB = 3;
	localparam int PS_TO_DIODE_LSB = 6;
	localparam int PS_TO_FULL_LSB = 9;
	localparam int MOD_DB1_BIT = 0;
	localparam int MOD_SP1_LSB = 1;
	localparam int MOD_DB2_BIT = 3;
	localparam int MOD_SP2_LSB = 4;
	localparam int MOD_DB3_BIT = 6;
	localparam int MOD_SP3_LSB = 7;
	localparam int MOD_PEAK_LSB = 9;
	localparam int MOD_HP_LSB = 11;
	localparam int MOD_GAIN_BIT = 13;
	localparam int TRIM_CURRENT_MONITOR_PIN_LSB = 0;
	localparam int TRIM_DROOP_LSB = 5;

	localparam logic [6:0] OFFSET_STEP_MV = 7'h14;
	localparam logic [2:0] SPEEDUP_ORIGINAL = 3'h0;

	typedef enum logic [1:0] {
		FULL_PHASE_STATE,
		LOW_PHASE_STATE,
		DIODE_EMULATION_STATE
	} power_state_t;

	typedef enum logic [1:0] {
		DECAY_HALF,
		DECAY_NORMAL,
		DECAY_QUARTER
	} decay_t;
endpackage

// ==== config_bank_store.sv ====
// Non-volatile configuration bank image with registered row read and whole-row store.
`timescale 1ns/10ps
`default_nettype none
module config_bank_store #(
	parameter int ROW_W = protection_cfg_pkg::W_ROW,
	parameter int BANKS = protection_cfg_pkg::NUM_BANKS
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic [$clog2(BANKS)-1:0] i_addr,
	input wire logic i_store,
	input wire logic [ROW_W-1:0] i_row,
	output logic [ROW_W-1:0] o_row
);
	localparam logic [ROW_W-1:0] DEF_ROW = {protection_cfg_pkg::DEF_TRIM,
		protection_cfg_pkg::DEF_MOD, protection_cfg_pkg::DEF_PS,
		protection_cfg_pkg::DEF_UV, protection_cfg_pkg::DEF_PROT};
	logic [ROW_W-1:0] mem [BANKS];

	// Every bank starts from the same factory image, since no real storage backs this model.
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int i = 0; i < BANKS; i++) begin
				mem[i] <= DEF_ROW;
			end
		end else if (i_store) begin
			mem[i_addr] <= i_row; // RULE_17
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_row <= '0;
		end else begin
			o_row <= mem[i_addr];
		end
	end
endmodule
`default_nettype wire

// ==== protection_and_transient_config_regs.sv ====
// Protection and transient configuration registers with bank loading and field decode.
// Notes on behaviour
// RULE_01: Nine independent protection disable bits, alert first.
// RULE_02: Four-bit low-output trip level below reference.
// RULE_03: Two-bit low-output qualification delay, 10 to 120us.
// RULE_04: Action bit: monitor only, or hiccup restart.
// RULE_05: Two-bit bottom clamp, 20 to 80mV.
// RULE_06: Offset into diode state, 20mV steps, one way.
// RULE_07: Offset only from low to full phase.
// RULE_08: Power states: 0 full, 1 low, 2 diode.
// RULE_09: Modulation fields apply with original speedup only.
// RULE_10: Per phase count dead-band bit and decay field.
// RULE_11: Peak-detect and high-pass capacitors, 1 to 4pF.
// RULE_12: Bit 13 picks 1x or 2x balance gain.
// RULE_13: Monitor trim, sign-magnitude quarter microamp codes; code maps sign-set codes to minus magnitude minus one.
// RULE_14: Monitor trim injected only while droop enabled.
// RULE_15: Droop trim always injected, same code mapping.
// RULE_16: Write-protect level 10h, trims at 20h.
// RULE_17: Defaults load from selected bank; bank also stores.
// RULE_18: Reads return stored value; upper bits zero.
`timescale 1ns/10ps
`default_nettype none
module protection_and_transient_config_regs (
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire logic [7:0] i_cmd_code,
	input wire logic i_wr_stb,
	input wire logic [15:0] i_wr_data,
	input wire logic i_rd_stb,
	input wire logic [7:0] i_wp_level,
	input wire logic [2:0] i_bank_strap,
	input wire logic i_bank_load,
	input wire logic i_bank_store,
	input wire logic i_droop_enable,
	input wire logic [2:0] i_speedup_select,
	input wire logic [1:0] i_power_state,
	input wire logic [2:0] i_phase_count,
	output logic [15:0] o_rd_data,
	output logic o_rd_valid,
	output logic o_wr_refused,
	output logic o_busy,
	output logic [8:0] o_protect_disable,
	output logic [8:0] o_uv_level_mv,
	output logic [11:0] o_uv_delay_cycles,
	output logic o_uv_hiccup,
	output logic [6:0] o_clamp_mv,
	output logic [7:0] o_transition_offset_mv,
	output logic o_transition_stb,
	output logic o_mod_fields_active,
	output logic o_deadband_reduced,
	output logic [1:0] o_decay_rate,
	output logic [2:0] o_peak_cap_pf,
	output logic [2:0] o_highpass_cap_pf,
	output logic o_balance_gain_2x,
	output logic signed [5:0] o_current_monitor_pin_trim_qua,
	output logic signed [5:0] o_droop_trim_qua
);
	typedef enum logic [1:0] {ST_BOOT, ST_IDLE, ST_FETCH, ST_APPLY} load_state_t;

	logic rst_s1_r, rst_n_r;
	logic [2:0] strap_s1_r, strap_s2_r, strap_s3_r;
	logic [1:0] settle_r;
	load_state_t state_r;
	logic [2:0] bank_sel_r;
	logic [8:0] prot_r;
	logic [6:0] uv_r;
	logic [11:0] ps_r;
	logic [13:0] mod_r;
	logic [9:0] trim_r;
	logic [protection_cfg_pkg::W_ROW-1:0] row_out, row_in;
	logic wr_ok;
	logic [7:0] reg_level;
	protection_cfg_pkg::power_state_t ps_now, ps_prev_r;
	logic db_sel;
	logic [1:0] sp_sel;

	function automatic logic signed [5:0] sm_trim(input logic [4:0] code);
		if (code[4]) begin
			sm_trim = -$signed({2'h0, code[3:0]}) - 6'sh01;
		end else begin
			sm_trim = $signed({2'h0, code[3:0]});
		end
	endfunction

	function automatic logic [1:0] decay_of(input logic [1:0] code);
		case (code)
			2'h1: decay_of = protection_cfg_pkg::DECAY_NORMAL;
			2'h2: decay_of = protection_cfg_pkg::DECAY_QUARTER;
			default: decay_of = protection_cfg_pkg::DECAY_HALF;
		endcase
	endfunction

	function automatic logic [2:0] cap_pf(input logic [1:0] code);
		cap_pf = {1'b0, code} + 3'h1;
	endfunction

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rst_s1_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n_r <= rst_s1_r;
		end
	end

	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			strap_s1_r <= 3'h0;
			strap_s2_r <= 3'h0;
			strap_s3_r <= 3'h0;
		end else begin
			strap_s1_r <= i_bank_strap;
			strap_s2_r <= strap_s1_r;
			strap_s3_r <= strap_s2_r;
		end
	end

	always_comb begin
		case (i_cmd_code)
			protection_cfg_pkg::CMD_TRIMS: reg_level = protection_cfg_pkg::WP_LEVEL_TRIM;
			protection_cfg_pkg::CMD_BANK_SELECT: reg_level = protection_cfg_pkg::WP_LEVEL_TRIM;
			default: reg_level = protection_cfg_pkg::WP_LEVEL_CFG;
		endcase
	end

	// A write is refused while a bank load is running so it cannot be overwritten silently.
	assign wr_ok = i_wr_stb && (state_r == ST_IDLE) &&
		((i_wp_level == 8'h00) || (i_wp_level < reg_level)); // RULE_16

	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			state_r <= ST_BOOT;
			settle_r <= 2'h0;
			bank_sel_r <= 3'h0;
		end else begin
			case (state_r)
				ST_BOOT: begin
					if (strap_s2_r != strap_s3_r) begin
						settle_r <= 2'h0;
					end else if (settle_r == 2'(protection_cfg_pkg::STRAP_SETTLE - 1)) begin
						bank_sel_r <= strap_s3_r;
						state_r <= ST_FETCH;
					end else begin
						settle_r <= settle_r + 2'h1;
					end
				end
				ST_IDLE: begin
					if (wr_ok && i_cmd_code == protection_cfg_pkg::CMD_BANK_SELECT) begin
						bank_sel_r <= i_wr_data[2:0];
					end else if (i_bank_load) begin
						state_r <= ST_FETCH; // RULE_17
					end
				end
				ST_FETCH: state_r <= ST_APPLY;
				ST_APPLY: state_r <= ST_IDLE;
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	assign row_in = {trim_r, mod_r, ps_r, uv_r, prot_r};

	config_bank_store #(
		.ROW_W(protection_cfg_pkg::W_ROW),
		.BANKS(protection_cfg_pkg::NUM_BANKS)
	) u_bank (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(rst_n_r),
		.i_addr(bank_sel_r),
		.i_store(i_bank_store && state_r == ST_IDLE), // RULE_17
		.i_row(row_in),
		.o_row(row_out)
	);

	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			prot_r <= protection_cfg_pkg::DEF_PROT;
			uv_r <= protection_cfg_pkg::DEF_UV;
			ps_r <= protection_cfg_pkg::DEF_PS;
			mod_r <= protection_cfg_pkg::DEF_MOD;
			trim_r <= protection_cfg_pkg::DEF_TRIM;
		end else if (state_r == ST_APPLY) begin
			prot_r <= row_out[protection_cfg_pkg::ROW_PROT +: protection_cfg_pkg::W_PROT];
			uv_r <= row_out[protection_cfg_pkg::ROW_UV +: protection_cfg_pkg::W_UV];
			ps_r <= row_out[protection_cfg_pkg::ROW_PS +: protection_cfg_pkg::W_PS];
			mod_r <= row_out[protection_cfg_pkg::ROW_MOD +: protection_cfg_pkg::W_MOD];
			trim_r <= row_out[protection_cfg_pkg::ROW_TRIM +: protection_cfg_pkg::W_TRIM]; // RULE_17
		end else if (wr_ok) begin
			case (i_cmd_code)
				protection_cfg_pkg::CMD_PROT_DISABLE: prot_r <= i_wr_data[8:0]; // RULE_18
				protection_cfg_pkg::CMD_UV_CFG: uv_r <= i_wr_data[6:0];
				protection_cfg_pkg::CMD_PS_TUNE: ps_r <= i_wr_data[11:0];
				protection_cfg_pkg::CMD_MOD_TUNE: mod_r <= i_wr_data[13:0];
				protection_cfg_pkg::CMD_TRIMS: trim_r <= i_wr_data[9:0];
				default: prot_r <= prot_r;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			o_rd_data <= 16'h0000;
			o_rd_valid <= 1'b0;
			o_wr_refused <= 1'b0;
			o_busy <= 1'b1;
		end else begin
			o_rd_valid <= i_rd_stb;
			o_wr_refused <= i_wr_stb && !wr_ok;
			o_busy <= (state_r != ST_IDLE) || i_bank_load;
			if (i_rd_stb) begin
				case (i_cmd_code)
					protection_cfg_pkg::CMD_BANK_SELECT: o_rd_data <= {13'h0000, bank_sel_r};
					protection_cfg_pkg::CMD_PROT_DISABLE: o_rd_data <= {7'h00, prot_r}; // RULE_18
					protection_cfg_pkg::CMD_UV_CFG: o_rd_data <= {9'h000, uv_r};
					protection_cfg_pkg::CMD_PS_TUNE: o_rd_data <= {4'h0, ps_r};
					protection_cfg_pkg::CMD_MOD_TUNE: o_rd_data <= {2'h0, mod_r};
					protection_cfg_pkg::CMD_TRIMS: o_rd_data <= {6'h00, trim_r};
					default: o_rd_data <= 16'h0000;
				endcase
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			o_protect_disable <= 9'h000;
			o_uv_level_mv <= 9'h000;
			o_uv_delay_cycles <= protection_cfg_pkg::UV_DLY0_CYC;
			o_uv_hiccup <= 1'b0;
			o_clamp_mv <= 7'h00;
		end else begin
			o_protect_disable <= prot_r; // RULE_01
			case (uv_r[protection_cfg_pkg::UV_LEVEL_LSB +: 4]) // RULE_02
				4'h0: o_uv_level_mv <= 9'h069;
				4'h1: o_uv_level_mv <= 9'h08D;
				4'h2: o_uv_level_mv <= 9'h0B2;
				4'h3: o_uv_level_mv <= 9'h0D6;
				4'h4: o_uv_level_mv <= 9'h0FC;
				4'h5: o_uv_level_mv <= 9'h123;
				4'h6: o_uv_level_mv <= 9'h148;
				default: o_uv_level_mv <= 9'h192;
			endcase
			case (uv_r[protection_cfg_pkg::UV_DELAY_LSB +: 2]) // RULE_03
				2'h0: o_uv_delay_cycles <= protection_cfg_pkg::UV_DLY0_CYC;
				2'h1: o_uv_delay_cycles <= protection_cfg_pkg::UV_DLY1_CYC;
				2'h2: o_uv_delay_cycles <= protection_cfg_pkg::UV_DLY2_CYC;
				default: o_uv_delay_cycles <= protection_cfg_pkg::UV_DLY3_CYC;
			endcase
			o_uv_hiccup <= uv_r[protection_cfg_pkg::UV_ACTION_BIT]; // RULE_04
			o_clamp_mv <= 7'(({5'h00, ps_r[protection_cfg_pkg::PS_CLAMP_LSB +: 2]} + 7'h01)
				* protection_cfg_pkg::OFFSET_STEP_MV); // RULE_05
		end
	end

	assign ps_now = protection_cfg_pkg::power_state_t'(i_power_state); // RULE_08

	// Offsets are reported once per transition; the reverse directions get no offset at all.
	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			ps_prev_r <= protection_cfg_pkg::FULL_PHASE_STATE;
			o_transition_offset_mv <= 8'h00;
			o_transition_stb <= 1'b0;
		end else begin
			ps_prev_r <= ps_now;
			o_transition_stb <= 1'b0;
			if (ps_now == protection_cfg_pkg::DIODE_EMULATION_STATE &&
				ps_prev_r != protection_cfg_pkg::DIODE_EMULATION_STATE) begin
				o_transition_offset_mv <= 8'({5'h00, ps_r[protection_cfg_pkg::PS_TO_DIODE_LSB +: 3]}
					* {1'b0, protection_cfg_pkg::OFFSET_STEP_MV}); // RULE_06
				o_transition_stb <= 1'b1;
			end else if (ps_now == protection_cfg_pkg::FULL_PHASE_STATE &&
				ps_prev_r == protection_cfg_pkg::LOW_PHASE_STATE) begin
				o_transition_offset_mv <= 8'({6'h00, ps_r[protection_cfg_pkg::PS_TO_FULL_LSB +: 2]}
					* {1'b0, protection_cfg_pkg::OFFSET_STEP_MV}); // RULE_07
				o_transition_stb <= 1'b1;
			end else if (ps_now != ps_prev_r) begin
				o_transition_offset_mv <= 8'h00;
				o_transition_stb <= 1'b1;
			end
		end
	end

	always_comb begin
		case (i_phase_count)
			3'h0, 3'h1: begin
				db_sel = mod_r[protection_cfg_pkg::MOD_DB1_BIT];
				sp_sel = mod_r[protection_cfg_pkg::MOD_SP1_LSB +: 2];
			end
			3'h2: begin
				db_sel = mod_r[protection_cfg_pkg::MOD_DB2_BIT];
				sp_sel = mod_r[protection_cfg_pkg::MOD_SP2_LSB +: 2];
			end
			default: begin
				db_sel = mod_r[protection_cfg_pkg::MOD_DB3_BIT];
				sp_sel = mod_r[protection_cfg_pkg::MOD_SP3_LSB +: 2];
			end
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			o_mod_fields_active <= 1'b0;
			o_deadband_reduced <= 1'b0;
			o_decay_rate <= protection_cfg_pkg::DECAY_HALF;
			o_peak_cap_pf <= 3'h1;
			o_highpass_cap_pf <= 3'h1;
			o_balance_gain_2x <= 1'b0;
		end else begin
			o_mod_fields_active <= (i_speedup_select == protection_cfg_pkg::SPEEDUP_ORIGINAL); // RULE_09
			o_deadband_reduced <= db_sel; // RULE_10
			o_decay_rate <= decay_of(sp_sel); // RULE_10
			o_peak_cap_pf <= cap_pf(mod_r[protection_cfg_pkg::MOD_PEAK_LSB +: 2]); // RULE_11
			o_highpass_cap_pf <= cap_pf(mod_r[protection_cfg_pkg::MOD_HP_LSB +: 2]); // RULE_11
			o_balance_gain_2x <= mod_r[protection_cfg_pkg::MOD_GAIN_BIT]; // RULE_12
		end
	end

	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			o_current_monitor_pin_trim_qua <= 6'sh00;
			o_droop_trim_qua <= 6'sh00;
		end else begin
			o_current_monitor_pin_trim_qua <= i_droop_enable ?
				sm_trim(trim_r[protection_cfg_pkg::TRIM_CURRENT_MONITOR_PIN_LSB +: 5]) : 6'sh00; // RULE_13 RULE_14
			o_droop_trim_qua <= sm_trim(trim_r[protection_cfg_pkg::TRIM_DROOP_LSB +: 5]); // RULE_15
		end
	end
endmodule
`default_nettype wire

// ==== protection_cfg_asserts.sv ====
// Checker for access, protection and timing at the ports of the config registers.
`timescale 1ns/10ps
`default_nettype none
module protection_cfg_asserts (
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire logic [7:0] i_cmd_code,
	input wire logic i_wr_stb,
	input wire logic i_rd_stb,
	input wire logic [7:0] i_wp_level,
	input wire logic i_bank_load,
	input wire logic i_droop_enable,
	input wire logic [1:0] i_power_state,
	input wire logic [15:0] o_rd_data,
	input wire logic o_rd_valid,
	input wire logic o_wr_refused,
	input wire logic o_busy,
	input wire logic o_transition_stb,
	input wire logic signed [5:0] o_current_monitor_pin_trim_qua
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);
	logic mapped;
	logic cfg_code;
	assign mapped = i_cmd_code inside {8'hDE, 8'hDF, [8'hE1:8'hE4]};
	assign cfg_code = i_cmd_code inside {8'hDF, [8'hE1:8'hE3]};
	// A load written in the same cycle as a bank change is dropped, so it is excluded here.
	sequence load_taken;
		i_bank_load && !o_busy && !(i_wr_stb && i_cmd_code == 8'hDE);
	endsequence
	sequence busy_seen;
		##[1:2] o_busy;
	endsequence
	chk_rd_answer: assert property (i_rd_stb |=> o_rd_valid)
		else $error("read strobe not answered next cycle");
	chk_valid_cause: assert property (o_rd_valid |-> $past(i_rd_stb))
		else $error("read valid without a read strobe");
	chk_unmapped_zero: assert property (i_rd_stb && !mapped |=> o_rd_data == 16'h0000)
		else $error("unmapped read returned nonzero data");
	chk_cfg_protect: assert property (i_wr_stb && cfg_code && i_wp_level >= 8'h10 |=> o_wr_refused)
		else $error("protected config write not refused");
	chk_trim_protect: assert property ((i_wr_stb && i_cmd_code == 8'hE4 && i_wp_level >= 8'h20)
		|=> o_wr_refused)
		else $error("protected trim write not refused");
	chk_refuse_cause: assert property (o_wr_refused |-> $past(i_wr_stb))
		else $error("refusal without a write strobe");
	chk_current_monitor_pin_gate: assert property (!o_busy && !$past(i_droop_enable) |-> o_current_monitor_pin_trim_qua == 6'sd0)
		else $error("monitor trim present with droop off");
	chk_state_stb: assert property (!o_busy && $changed(i_power_state) |=> o_transition_stb)
		else $error("power state change without transition strobe");
	chk_load_busy: assert property (load_taken |-> busy_seen)
		else $error("bank load did not raise busy");
endmodule
bind protection_and_transient_config_regs protection_cfg_asserts chk_u (.i_ref_clk, .i_nrst,
	.i_cmd_code, .i_wr_stb, .i_rd_stb, .i_wp_level, .i_bank_load, .i_droop_enable,
	.i_power_state, .o_rd_data, .o_rd_valid, .o_wr_refused, .o_busy, .o_transition_stb,
	.o_current_monitor_pin_trim_qua);
`default_nettype wire

// ==== mgmt_host_model.sv ====
// Management host model issuing single register writes and reads.
`timescale 1ns/10ps
`default_nettype none
module mgmt_host_model (
	input wire logic i_ref_clk,
	input wire logic [15:0] i_rd_data,
	input wire logic i_rd_valid,
	input wire logic i_wr_refused,
	output logic [7:0] o_cmd_code,
	output logic o_wr_stb,
	output logic [15:0] o_wr_data,
	output logic o_rd_stb
);
	initial begin
		o_cmd_code = 8'h00;
		o_wr_stb = 1'b0;
		o_wr_data = 16'h0000;
		o_rd_stb = 1'b0;
	end
	// Idle code and data lines show the inverse of the last value so a stale word is never mistaken for live data.
	task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
		output logic [15:0] rdata, output logic flag);
		@(posedge i_ref_clk);
		o_cmd_code <= code;
		o_wr_data <= data;
		o_wr_stb <= wr;
		o_rd_stb <= !wr;
		@(posedge i_ref_clk);
		o_wr_stb <= 1'b0;
		o_rd_stb <= 1'b0;
		o_cmd_code <= ~code;
		o_wr_data <= ~data;
		@(posedge i_ref_clk);
		rdata = i_rd_data;
		flag = wr ? i_wr_refused : i_rd_valid;
	endtask
endmodule
`default_nettype wire

// ==== test_protection_and_transient_config_regs.sv ====
// Self-checking bench for the protection and transient configuration registers.
`timescale 1ns/10ps
`default_nettype none
module test_protection_and_transient_config_regs;
	logic i_ref_clk, i_nrst, i_wr_stb, i_rd_stb, i_bank_load, i_bank_store, i_droop_enable;
	logic o_rd_valid, o_wr_refused, o_busy, o_uv_hiccup, o_transition_stb, o_mod_fields_active;
	logic o_deadband_reduced, o_balance_gain_2x, flag;
	logic [7:0] i_cmd_code, i_wp_level, o_transition_offset_mv;
	logic [15:0] i_wr_data, o_rd_data, rd;
	logic [2:0] i_bank_strap, i_speedup_select, i_phase_count, o_peak_cap_pf, o_highpass_cap_pf;
	logic [1:0] i_power_state, o_decay_rate;
	logic [8:0] o_protect_disable, o_uv_level_mv;
	logic [11:0] o_uv_delay_cycles;
	logic [6:0] o_clamp_mv;
	logic signed [5:0] o_current_monitor_pin_trim_qua, o_droop_trim_qua;
	logic [31:0] seed = 32'h88F0;
	logic [15:0] mdl[5] = '{default: 16'h0000};
	logic [15:0] bank[8][5] = '{default: '{default: 16'h0000}};
	logic [7:0] codes[5] = '{8'hDF, 8'hE1, 8'hE2, 8'hE3, 8'hE4};
	logic [15:0] masks[5] = '{16'h01FF, 16'h007F, 16'h0FFF, 16'h3FFF, 16'h03FF};
	logic [1:0] pseq[6] = '{2'h2, 2'h0, 2'h1, 2'h2, 2'h1, 2'h0};
	int dly[4] = '{10, 20, 40, 120};
	int uv[8] = '{105, 141, 178, 214, 252, 291, 328, 402};
	int n_fail = 0, compares = 0, cyc = 0;
	protection_and_transient_config_regs dut_u (.i_ref_clk, .i_nrst, .i_cmd_code, .i_wr_stb,
		.i_wr_data, .i_rd_stb, .i_wp_level, .i_bank_strap, .i_bank_load, .i_bank_store,
		.i_droop_enable, .i_speedup_select, .i_power_state, .i_phase_count, .o_rd_data,
		.o_rd_valid, .o_wr_refused, .o_busy, .o_protect_disable, .o_uv_level_mv,
		.o_uv_delay_cycles, .o_uv_hiccup, .o_clamp_mv, .o_transition_offset_mv,
		.o_transition_stb, .o_mod_fields_active, .o_deadband_reduced, .o_decay_rate,
		.o_peak_cap_pf, .o_highpass_cap_pf, .o_balance_gain_2x, .o_current_monitor_pin_trim_qua,
		.o_droop_trim_qua);
	mgmt_host_model host_u (.i_ref_clk(i_ref_clk), .i_rd_data(o_rd_data), .i_rd_valid(o_rd_valid),
		.i_wr_refused(o_wr_refused), .o_cmd_code(i_cmd_code), .o_wr_stb(i_wr_stb),
		.o_wr_data(i_wr_data), .o_rd_stb(i_rd_stb));
	initial begin
		i_ref_clk = 1'b0;
		forever #20 i_ref_clk = ~i_ref_clk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic int trim(input logic [4:0] c);
		return c < 5'h10 ? int'(c) : 15 - int'(c);
	endfunction
	function automatic int ofs(input logic [1:0] from, input logic [1:0] to);
		if (to == 2'h2 && from != 2'h2) return mdl[2][8:6] * 20;
		if (from == 2'h1 && to == 2'h0) return mdl[2][10:9] * 20;
		return 0;
	endfunction
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares = compares + 1;
		if (got !== exp) begin
			n_fail = n_fail + 1;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input int i, input logic [15:0] d, input logic refuse);
		host_u.xfer(1'b1, codes[i], d, rd, flag);
		chk("wr_refused", 16'(refuse), 16'(flag));
		if (!refuse) mdl[i] = d & masks[i];
	endtask
	task automatic rd_chk(input int i);
		host_u.xfer(1'b0, codes[i], 16'h0000, rd, flag);
		chk("rd_valid", 16'h0001, 16'(flag));
		chk("rd_data", mdl[i], rd);
	endtask
	task automatic wait_idle();
		for (int k = 0; k < 40 && o_busy !== 1'b0; k++) @(posedge i_ref_clk);
		chk("busy", 16'h0000, 16'(o_busy));
	endtask
	task automatic pulse(input logic st);
		@(posedge i_ref_clk);
		i_bank_store <= st;
		i_bank_load <= !st;
		@(posedge i_ref_clk);
		i_bank_store <= 1'b0;
		i_bank_load <= 1'b0;
		repeat (3) @(posedge i_ref_clk);
		wait_idle();
	endtask
	task automatic dec_chk();
		int sh;
		logic [1:0] dc;
		sh = i_phase_count < 3'h2 ? 0 : (i_phase_count == 3'h2 ? 3 : 6);
		dc = mdl[3][sh+1 +: 2];
		chk("protect", mdl[0], 16'(o_protect_disable));
		chk("uv_level", 16'(mdl[1][3] ? 402 : uv[mdl[1][2:0]]), 16'(o_uv_level_mv));
		chk("uv_delay", 16'(dly[mdl[1][5:4]] * protection_cfg_pkg::CYC_PER_US),
			16'(o_uv_delay_cycles));
		chk("hiccup", 16'(mdl[1][6]), 16'(o_uv_hiccup));
		chk("clamp", 16'((mdl[2][4:3] + 1) * 20), 16'(o_clamp_mv));
		chk("mod_active", 16'(i_speedup_select == 3'h0), 16'(o_mod_fields_active));
		chk("deadband", 16'(mdl[3][sh]), 16'(o_deadband_reduced));
		chk("decay", dc == 2'h3 ? 16'h0000 : 16'(dc), 16'(o_decay_rate));
		chk("peak_cap", 16'(mdl[3][10:9] + 1), 16'(o_peak_cap_pf));
		chk("hp_cap", 16'(mdl[3][12:11] + 1), 16'(o_highpass_cap_pf));
		chk("gain", 16'(mdl[3][13]), 16'(o_balance_gain_2x));
		chk("current_monitor_pin", i_droop_enable ? 16'(trim(mdl[4][4:0])) : 16'h0000,
			16'(o_current_monitor_pin_trim_qua));
		chk("droop", 16'(trim(mdl[4][9:5])), 16'(o_droop_trim_qua));
	endtask
	task automatic ps_chk(input logic [1:0] to);
		int e;
		int k;
		e = ofs(i_power_state, to);
		@(posedge i_ref_clk);
		i_power_state <= to;
		for (k = 0; k < 6 && o_transition_stb !== 1'b1; k++) @(posedge i_ref_clk);
		chk("stb", 16'h0001, 16'(o_transition_stb));
		chk("offset", 16'(e), 16'(o_transition_offset_mv));
	endtask
	always @(posedge i_ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			n_fail = n_fail + 1;
			tally_and_finish();
		end
	end
	initial begin
		i_nrst = 1'b0;
		i_wp_level = 8'h00;
		i_bank_strap = 3'h5;
		i_bank_load = 1'b0;
		i_bank_store = 1'b0;
		i_droop_enable = 1'b0;
		i_speedup_select = 3'h0;
		i_power_state = 2'h0;
		i_phase_count = 3'h0;
		repeat (8) @(posedge i_ref_clk);
		i_nrst <= 1'b1;
		repeat (3) @(posedge i_ref_clk);
		wait_idle();
		for (int i = 0; i < 5; i++) rd_chk(i);
		host_u.xfer(1'b0, 8'hE0, 16'h0000, rd, flag);
		chk("unmapped", 16'h0000, rd);
		host_u.xfer(1'b0, 8'hDE, 16'h0000, rd, flag);
		chk("boot_bank", 16'h0005, rd);
		$display("done reset values");
		for (int c = 0; c < 16; c++) begin
			for (int i = 0; i < 5; i++) begin
				seed = lfsr(seed);
				wr(i, i == 1 ? 16'({c[0], c[1:0], c[3:0]}) : seed[15:0], 1'b0);
			end
			for (int i = 0; i < 5; i++) rd_chk(i);
			i_droop_enable <= seed[16];
			i_speedup_select <= seed[19:17] & {3{seed[20]}};
			i_phase_count <= 3'(c);
			repeat (3) @(posedge i_ref_clk);
			dec_chk();
		end
		$display("done field decode");
		i_wp_level <= 8'h10;
		wr(0, 16'h0155, 1'b1);
		wr(4, 16'h0155, 1'b0);
		i_wp_level <= 8'h20;
		wr(3, 16'h1555, 1'b1);
		wr(4, 16'h02AA, 1'b1);
		i_wp_level <= 8'h00;
		for (int i = 0; i < 5; i++) rd_chk(i);
		$display("done write protect");
		wr(2, seed[15:0] | 16'h0240, 1'b0);
		for (int i = 0; i < 6; i++) ps_chk(pseq[i]);
		$display("done power states");
		host_u.xfer(1'b1, 8'hDE, 16'h0002, rd, flag);
		pulse(1'b1);
		bank[2] = mdl;
		for (int i = 0; i < 5; i++) wr(i, 16'h5A5A, 1'b0);
		pulse(1'b0);
		mdl = bank[2];
		for (int i = 0; i < 5; i++) rd_chk(i);
		host_u.xfer(1'b0, 8'hDE, 16'h0000, rd, flag);
		chk("bank_select", 16'h0002, rd);
		host_u.xfer(1'b1, 8'hDE, 16'h0003, rd, flag);
		pulse(1'b0);
		mdl = bank[3];
		for (int i = 0; i < 5; i++) rd_chk(i);
		$display("done bank load");
		tally_and_finish();
	end
endmodule
`default_nettype wire
